/* File: rms_pkg.sv */
package rms_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned DEBOUNCE_MS    = 60;
	localparam int unsigned CONVERT_MS     = 200;
	localparam int unsigned RESULT_MS      = 260;
	localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1000) * DEBOUNCE_MS;
	localparam int unsigned CONVERT_CYC    = (CLK_HZ / 1000) * CONVERT_MS;
	localparam int unsigned MS_CYC         = CLK_HZ / 1000;
	localparam int unsigned SEC_MS         = 1000;

	// ****************************************************************
	// widths and reset values
	// ****************************************************************
	localparam int unsigned TIME_W         = 10;
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned CNT_W          = 32;
	localparam logic [TIME_W-1:0] TIME_RST = 10'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [3:0] {
		RMS_IDLE   = 4'b0001,
		RMS_CHARGE = 4'b0010,
		RMS_MEAS   = 4'b0100,
		RMS_DONE   = 4'b1000
	} rms_state_t;

	// converter sample and result carrier
	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] value;
	} rms_sample_t;

	typedef struct packed {
		logic [DATA_W-1:0] reading;
		logic              pass;
	} rms_result_t;

	// timer setup, seconds, 0 means not set
	typedef struct packed {
		logic [TIME_W-1:0] charge_s;
		logic [TIME_W-1:0] meas_s;
	} rms_times_t;

endpackage

/* File: rms_sequencer.sv */
`timescale 1ns/1ps
module rms_sequencer
	import rms_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = rms_pkg::DEBOUNCE_CYC,
	parameter int unsigned CONVERT_CYCLES  = rms_pkg::CONVERT_CYC,
	parameter int unsigned MS_CYCLES       = rms_pkg::MS_CYC
) (
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// remote contact, high when closed, asynchronous
	input  wire logic                  remote_in,
	// timer setup and judgement level
	input  wire rms_pkg::rms_times_t   times,
	input  wire logic [rms_pkg::DATA_W-1:0] pass_level,
	// converter samples
	input  wire rms_pkg::rms_sample_t  sample,
	// sequencing outputs
	output logic                       charging,
	output logic                       measuring,
	output logic                       remote_level,
	// result
	output rms_pkg::rms_result_t       result,
	output logic                       result_valid
);
	import rms_pkg::*;

	// ****************************************************************
	// input synchroniser and debounce
	// ****************************************************************
	logic             sync1_r, sync2_r;
	logic             level_r;
	logic [CNT_W-1:0] deb_cnt_r;
	logic             on_evt, off_evt;
	logic             deb_hit;

	// two stages before anything looks at the pin
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
		end else begin
			sync1_r <= remote_in;
			sync2_r <= sync1_r;
		end
	end

	// a new level must stand unbroken before it counts; any bounce restarts it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_r   <= 1'b0;
			deb_cnt_r <= '0;
		end else if (sync2_r == level_r) begin
			deb_cnt_r <= '0;
		end else if (deb_cnt_r == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
			level_r   <= sync2_r;
			deb_cnt_r <= '0;
		end else begin
			deb_cnt_r <= deb_cnt_r + 1'b1;
		end
	end

	// last cycle of an unbroken run on a level that still differs
	assign deb_hit      = (sync2_r != level_r) && (deb_cnt_r == CNT_W'(DEBOUNCE_CYCLES - 1));
	assign on_evt       = deb_hit && sync2_r;
	assign off_evt      = deb_hit && !sync2_r;
	assign remote_level = level_r;

	// ****************************************************************
	// millisecond tick and phase timer
	// ****************************************************************
	logic [CNT_W-1:0] ms_div_r;
	logic             ms_tick;
	logic [CNT_W-1:0] phase_ms_r;
	logic             phase_load;
	logic [CNT_W-1:0] phase_load_ms;
	logic             phase_up;
	rms_state_t       state_r;

	// one-cycle enable per millisecond, free running
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ms_div_r <= '0;
		end else if (ms_div_r == CNT_W'(MS_CYCLES - 1)) begin
			ms_div_r <= '0;
		end else begin
			ms_div_r <= ms_div_r + 1'b1;
		end
	end
	// free running, so the first tick of a phase may come early: a phase can run one tick short
	assign ms_tick = (ms_div_r == CNT_W'(MS_CYCLES - 1));

	// counts down the active phase; granularity is one tick
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			phase_ms_r <= '0;
		end else if (phase_load) begin
			phase_ms_r <= phase_load_ms;
		end else if (ms_tick && phase_ms_r != '0) begin
			phase_ms_r <= phase_ms_r - 1'b1;
		end
	end
	assign phase_up = (phase_ms_r == CNT_W'(1)) && ms_tick;

	// ****************************************************************
	// phase sequencer
	// ****************************************************************
	rms_times_t times_r;
	logic       charge_set, meas_set;
	// the start decision looks at the live setup; the running phases use the copy
	assign charge_set = (times.charge_s != TIME_RST);
	assign meas_set   = (times_r.meas_s != TIME_RST);

	// setup is taken as the contact closes, so an edit mid-cycle cannot cut a phase short
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			times_r <= '{charge_s: TIME_RST, meas_s: TIME_RST};
		end else if (state_r == RMS_IDLE && on_evt) begin
			times_r <= times;
		end
	end

	// load the timer when a timed phase starts
	always_comb begin
		phase_load    = 1'b0;
		phase_load_ms = '0;
		if (state_r == RMS_IDLE && on_evt) begin
			phase_load    = 1'b1;
			phase_load_ms = charge_set ? CNT_W'(times.charge_s) * CNT_W'(SEC_MS)
			                           : CNT_W'(times.meas_s) * CNT_W'(SEC_MS);
		end else if (state_r == RMS_CHARGE && phase_up) begin
			phase_load    = 1'b1;
			phase_load_ms = CNT_W'(times_r.meas_s) * CNT_W'(SEC_MS);
		end
	end

	// phase order; an accepted opening beats every running timer
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RMS_IDLE;
		end else begin
			unique case (state_r)
				RMS_IDLE: begin
					if (on_evt) begin
						state_r <= charge_set ? RMS_CHARGE : RMS_MEAS;
					end
				end
				RMS_CHARGE: begin
					if (off_evt) begin
						state_r <= RMS_IDLE;
					end else if (phase_up) begin
						state_r <= RMS_MEAS;
					end
				end
				RMS_MEAS: begin
					if (off_evt) begin
						state_r <= RMS_IDLE;
					end else if (meas_set && phase_up) begin
						state_r <= RMS_DONE;
					end
				end
				RMS_DONE: begin
					// wait for the contact to open before re-arming
					if (off_evt) begin
						state_r <= RMS_IDLE;
					end
				end
				default: state_r <= RMS_IDLE;
			endcase
		end
	end

	// levels are decoded by comparing the whole one-hot state_r with RMS_CHARGE and RMS_MEAS, not taken off single state bits
	assign charging  = (state_r == RMS_CHARGE);
	assign measuring = (state_r == RMS_MEAS);

	// ****************************************************************
	// conversion window and result
	// ****************************************************************
	logic [CNT_W-1:0] conv_cnt_r;
	logic             conv_done;

	// a conversion needs the full window inside the measuring phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt_r <= '0;
		end else if (state_r != RMS_MEAS) begin
			conv_cnt_r <= '0;
		end else if (conv_cnt_r != CNT_W'(CONVERT_CYCLES)) begin
			conv_cnt_r <= conv_cnt_r + 1'b1;
		end
	end
	// stays true for the rest of the phase once the window has run out
	assign conv_done = (state_r == RMS_MEAS) && (conv_cnt_r == CNT_W'(CONVERT_CYCLES));

	// results come only from converter words, and only after the window
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			result       <= '{reading: DATA_RST, pass: 1'b0};
			result_valid <= 1'b0;
		end else if (conv_done && sample.valid) begin
			result.reading <= sample.value;
			result.pass    <= (sample.value >= pass_level);
			result_valid   <= 1'b1;
		end else begin
			result_valid <= 1'b0;
		end
	end

endmodule // rms_sequencer

/* File: rms_switch.sv */
`timescale 1ns/1ps
module rms_switch #(
	parameter int unsigned CHATTER = 6
) (
	// clock and user side
	input  wire logic mclk,
	input  wire logic press,
	// contact
	output logic      remote_in
);
	int unsigned n_r    = 0;
	logic        last_r = 1'b0;
	logic        sw_r   = 1'b0;
	// a real contact chatters after each move, so no edge is ever clean
	always_ff @(posedge mclk) begin
		last_r <= press;
		n_r    <= (press != last_r) ? CHATTER : ((n_r != 0) ? n_r - 1 : 0);
		sw_r   <= (n_r != 0) ? ~sw_r : press;
	end
	assign remote_in = sw_r;
endmodule // rms_switch

/* File: rms_chk.sv */
`timescale 1ns/1ps
module rms_chk
	import rms_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = 20,
	parameter int unsigned CONVERT_CYCLES  = 50
) (
	// watched ports
	input wire logic                   mclk,
	input wire logic                   rst_n,
	input wire logic                   remote_in,
	input wire rms_pkg::rms_times_t    times,
	input wire logic [rms_pkg::DATA_W-1:0] pass_level,
	input wire rms_pkg::rms_sample_t   sample,
	input wire logic                   charging,
	input wire logic                   measuring,
	input wire logic                   remote_level,
	input wire rms_pkg::rms_result_t   result,
	input wire logic                   result_valid
);
	int unsigned hi_r;
	int unsigned lo_r;
	int unsigned run_r;
	// steady run of raw input and length of the measuring phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hi_r  <= 0;
			lo_r  <= 0;
			run_r <= 0;
		end else begin
			hi_r  <= remote_in ? hi_r + 1 : 0;
			lo_r  <= remote_in ? 0 : lo_r + 1;
			run_r <= measuring ? run_r + 1 : 0;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_on; $rose(remote_level) |-> hi_r >= DEBOUNCE_CYCLES; endproperty
	a_on: assert property (p_on) else $error("on accepted too early");
	property p_off; $fell(remote_level) |-> lo_r >= DEBOUNCE_CYCLES; endproperty
	a_off: assert property (p_off) else $error("off accepted too early");
	property p_conv; result_valid |-> $past(measuring) && run_r >= CONVERT_CYCLES; endproperty
	a_conv: assert property (p_conv) else $error("result before conversion");
	property p_dig; result_valid |-> $past(sample.valid) && result.reading == $past(sample.value)
		&& result.pass == ($past(sample.value) >= $past(pass_level)); endproperty
	a_dig: assert property (p_dig) else $error("result not from sample");
	property p_tend; $fell(measuring) && remote_level |-> times.meas_s != 0; endproperty
	a_tend: assert property (p_tend) else $error("measuring ended without timer");
	property p_chg; $rose(remote_level) && times.charge_s != 0 |-> charging && !measuring; endproperty
	a_chg: assert property (p_chg) else $error("charge not started");
	property p_seq; $fell(charging) && remote_level |-> measuring; endproperty
	a_seq: assert property (p_seq) else $error("no measuring after charge");
	property p_free; $rose(remote_level) && times.charge_s == 0 |-> measuring; endproperty
	a_free: assert property (p_free) else $error("measuring not started");
	property p_open; $fell(remote_level) |-> !charging && !measuring; endproperty
	a_open: assert property (p_open) else $error("phase kept after opening");
endmodule // rms_chk

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	import rms_pkg::*;
	localparam int D = 20;
	localparam int C = 50;
	localparam int M = 4;
	localparam int T = 1000 * M;
	logic        mclk  = 1'b0;
	logic        rst_n = 1'b0;
	logic        press = 1'b0;
	logic        remote_in, charging, measuring, remote_level, result_valid;
	rms_times_t  times = '0;
	rms_sample_t sample = '0;
	rms_result_t result;
	logic [DATA_W-1:0] pass_level = 16'h0040;
	logic [DATA_W-1:0] last_v     = '0;
	int          num_errors = 0, samples_checked = 0, n_res = 0, k = 0, n;
	initial forever #2.5 mclk = ~mclk;
	// converter word every 8 cycles, a ramp that wraps so the judgement flips both ways
	always @(posedge mclk) begin
		k <= k + 1;
		sample <= '{valid: (k % 8 == 0), value: DATA_W'(k % 128)};
		if (sample.valid) last_v <= sample.value;
		if (result_valid === 1'b1) n_res <= n_res + 1;
	end
	rms_switch sw_u (.mclk(mclk), .press(press), .remote_in(remote_in));
	rms_sequencer #(.DEBOUNCE_CYCLES(D), .CONVERT_CYCLES(C), .MS_CYCLES(M)) dut_u (.mclk, .rst_n, .remote_in,
		.times, .pass_level, .sample, .charging, .measuring, .remote_level, .result, .result_valid);
	task check(string nm, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %0h seen %0h", nm, exp, got);
			num_errors++;
		end
	endtask
	task finish_test;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task cyc(int c);
		repeat (c) @(posedge mclk);
	endtask
	// bounded wait for charging or measuring to reach a level
	task hold(bit ch, logic v);
		n = 0;
		while ((ch ? charging : measuring) !== v && n < 9000) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 9000) begin
			num_errors++;
			finish_test();
		end
	endtask
	task rng(string nm, int a, int b);
		check(nm, 1, (n >= a && n <= b));
	endtask
	task t_bounce;
		press <= 1'b1;
		cyc(D - 5);
		press <= 1'b0;
		cyc(D + 40);
		check("level", 0, remote_level);
	endtask
	task t_short;
		n_res = 0;
		press <= 1'b1;
		cyc(D + 20);
		press <= 1'b0;
		cyc(2 * D + 40);
		check("results", 0, n_res);
	endtask
	task t_free;
		n_res = 0;
		press <= 1'b1;
		hold(0, 1);
		rng("on delay", D + 2, D + 12);
		n = 0;
		while (n_res == 0 && n < 200) begin
			@(posedge mclk);
			n++;
		end
		rng("result time", C, C + 10);
		check("reading", last_v, result.reading);
		check("judgement", last_v >= pass_level, result.pass);
		cyc(300);
		check("measuring", 1, measuring);
		press <= 1'b0;
		hold(0, 0);
		rng("off delay", D + 2, D + 12);
	endtask
	task t_timed(bit chg, bit early);
		times <= '{charge_s: TIME_W'(chg), meas_s: 10'h001};
		press <= 1'b1;
		hold(chg, 1);
		if (early) begin
			cyc(100);
			press <= 1'b0;
			hold(chg, 0);
			rng("abort", D + 2, D + 112);
			cyc(D);
			check("no meas", 0, measuring);
		end else begin
			if (chg) begin
				hold(1, 0);
				rng("charge len", T - M - 2, T + 2);
				check("meas", 1, measuring);
			end
			hold(0, 0);
			rng("meas len", T - M - 2, T + 2);
			press <= 1'b0;
			cyc(2 * D);
		end
		times <= '0;
		cyc(D);
	endtask
	initial begin
		cyc(2);
		rst_n <= 1'b1;
		cyc(2);
		t_bounce();
		t_short();
		t_free();
		t_timed(0, 0);
		t_timed(0, 1);
		t_timed(1, 0);
		t_timed(1, 1);
		finish_test();
	end
endmodule // testbench
bind rms_sequencer rms_chk #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .CONVERT_CYCLES(CONVERT_CYCLES)) chk_u (.mclk,
	.rst_n, .remote_in, .times, .pass_level, .sample, .charging, .measuring, .remote_level, .result, .result_valid);
